// *** core/srp_consts.svh ***
// constants of the serial register port: map, reset values, field positions
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SRP_REG_COUNT 23
`define SRP_LAST_ADDR 7'h16
`define SRP_STATUS_ADDR 7'h00
`define SRP_ROM_ADDR 7'h16
`define SRP_STATUS_W 6

// ----------------------------------------------------------------------
// command byte layout
// ----------------------------------------------------------------------
`define SRP_CMD_RW_BIT 0
`define SRP_CMD_ADDR_MSB 7
`define SRP_CMD_ADDR_LSB 1
`define SRP_BYTE_LAST_BIT 3'h7

// ----------------------------------------------------------------------
// reset values of the read-write registers
// ----------------------------------------------------------------------
`define SRP_RST_01 8'h04
`define SRP_RST_02 8'h3b
`define SRP_RST_03 8'h08
`define SRP_RST_04 8'h00
`define SRP_RST_05 8'h9b
`define SRP_RST_06 8'he4
`define SRP_RST_07 8'h00
`define SRP_RST_08 8'h01
`define SRP_RST_09 8'h00
`define SRP_RST_0A 8'h32
`define SRP_RST_0B 8'h41
`define SRP_RST_0C 8'h80
`define SRP_RST_0D 8'h02
`define SRP_RST_0E 8'h80
`define SRP_RST_0F 8'h04
`define SRP_RST_10 8'h80
`define SRP_RST_11 8'h08
`define SRP_RST_12 8'h80
`define SRP_RST_13 8'h10
`define SRP_RST_14 8'h00
`define SRP_RST_15 8'ha0

`endif

// *** core/srp_pkg.sv ***
// types shared by the serial register port and its users
package srp_pkg;

    // one register write handed on to the chip core
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } srp_wr_t;

    // phase of the current burst
    typedef enum logic [1:0] {
        SRP_CMD,
        SRP_WRITE,
        SRP_READ
    } srp_phase_t;

endpackage : srp_pkg

// *** core/srp_serial_register_port.sv ***
// four-wire serial register port with 23 byte registers and write stream
//
// Behaviour
// - the port acts only while the chip select pin is held low.
// - input bits are taken on serial clock rising edges, msb first.
// - a rising chip select ends the transfer and clears the burst state.
// - data out is released while chip select is high or no read runs.
// - there are 23 byte registers at addresses zero upward.
// - the command byte is a 7-bit address above a read (1) or write (0) bit.
// - each byte after the command byte is register data for the pointer.
// - during a write the pointer advances after each data byte, stored or not.
// - the pointer wraps from the last address, 22, back to zero.
// - a read command enables the output and streams registers upward.
// - during a read all input bits after the command byte are ignored.
// - address zero is a read-only status byte showing live flags.
`timescale 1ns/1ps
`include "srp_consts.svh"

module srp_serial_register_port #(
    parameter int REG_COUNT = `SRP_REG_COUNT,
    // identification byte; value is arbitrary
    parameter logic [7:0] ROM_VALUE = 8'h5a
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [`SRP_STATUS_W-1:0] statusIn,
    output logic sdo,
    output logic sdoOe,
    output logic cfgValid,
    input wire logic cfgReady,
    output srp_pkg::srp_wr_t cfgWord,
    output logic [REG_COUNT-1:0][7:0] cfgRegs,
    output logic overrun
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [1:0] csSync_r;
    logic [2:0] sclkSync_r;
    logic [1:0] sdiSync_r;
    logic [`SRP_STATUS_W-1:0] statS1_r;
    logic [`SRP_STATUS_W-1:0] statS2_r;
    logic active;
    logic sclkRise;
    logic sclkFall;
    logic sdiBit;
    srp_pkg::srp_phase_t phase_r;
    logic [2:0] bitCnt_r;
    logic [6:0] rxShift_r;
    logic [7:0] rxByte;
    logic byteDone;
    logic [6:0] ptr_r;
    logic [7:0] txShift_r;
    logic sdo_r;
    logic wrHit;
    logic [REG_COUNT-1:0][7:0] regs_r;
    srp_pkg::srp_wr_t fifoMem_r [2];
    logic wrIdx_r;
    logic rdIdx_r;
    logic [1:0] fifoCnt_r;
    logic fifoFull;
    logic push;
    logic pop;
    logic overrun_r;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // next pointer value, wrapping after the last address
    function automatic logic [6:0] nextAddr(input logic [6:0] p);
        logic [6:0] n;
        n = (p >= `SRP_LAST_ADDR) ? 7'h00 : p + 7'h01;
        return n;
    endfunction : nextAddr

    // only addresses between the status byte and the id byte store data
    function automatic logic writable(input logic [6:0] p);
        logic ok;
        ok = (p != `SRP_STATUS_ADDR) && (p != `SRP_ROM_ADDR)
            && (32'(p) < REG_COUNT);
        return ok;
    endfunction : writable

    // read value of one address; status is live, unmapped reads as zero
    function automatic logic [7:0] regRead(input logic [6:0] p);
        logic [7:0] v;
        v = 8'h00;
        if (p == `SRP_STATUS_ADDR) begin
            v = {2'h0, statS2_r};
        end else if (p == `SRP_ROM_ADDR) begin
            v = ROM_VALUE;
        end else if (32'(p) < REG_COUNT) begin
            v = regs_r[p[4:0]];
        end
        return v;
    endfunction : regRead

    // reset contents of each register slot
    function automatic logic [7:0] resetValue(input int idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            1: v = `SRP_RST_01;
            2: v = `SRP_RST_02;
            3: v = `SRP_RST_03;
            4: v = `SRP_RST_04;
            5: v = `SRP_RST_05;
            6: v = `SRP_RST_06;
            7: v = `SRP_RST_07;
            8: v = `SRP_RST_08;
            9: v = `SRP_RST_09;
            10: v = `SRP_RST_0A;
            11: v = `SRP_RST_0B;
            12: v = `SRP_RST_0C;
            13: v = `SRP_RST_0D;
            14: v = `SRP_RST_0E;
            15: v = `SRP_RST_0F;
            16: v = `SRP_RST_10;
            17: v = `SRP_RST_11;
            18: v = `SRP_RST_12;
            19: v = `SRP_RST_13;
            20: v = `SRP_RST_14;
            21: v = `SRP_RST_15;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : resetValue

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------

    // all pins are asynchronous to clk_sys; stage 0 feeds stage 1 only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            csSync_r <= 2'h3;
            sclkSync_r <= 3'h0;
            sdiSync_r <= 2'h0;
        end else begin
            csSync_r <= {csSync_r[0], csN};
            sclkSync_r <= {sclkSync_r[1:0], sclk};
            sdiSync_r <= {sdiSync_r[0], sdi};
        end
    end

    // status flags come from other logic in the chip, possibly async
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            statS1_r <= '0;
            statS2_r <= '0;
        end else begin
            statS1_r <= statusIn;
            statS2_r <= statS1_r;
        end
    end

    // edge detection works on stages 1 and 2, never on stage 0
    assign active = ~csSync_r[1];
    assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2] & active;
    assign sclkFall = ~sclkSync_r[1] & sclkSync_r[2] & active;
    assign sdiBit = sdiSync_r[1];

    // ------------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------------
    assign rxByte = {rxShift_r, sdiBit};
    assign byteDone = sclkRise && (bitCnt_r == `SRP_BYTE_LAST_BIT);

    // ------------------------------------------------------------------
    // burst sequencing: phase, bit count, pointer and shifters
    // ------------------------------------------------------------------

    // a high chip select resets phase, bit count and sdo, so a cut-off burst is harmless
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_r <= srp_pkg::SRP_CMD;
            bitCnt_r <= 3'h0;
            rxShift_r <= 7'h00;
            ptr_r <= 7'h00;
            txShift_r <= 8'h00;
            sdo_r <= 1'b0;
        end else if (!active) begin
            phase_r <= srp_pkg::SRP_CMD;
            bitCnt_r <= 3'h0;
            sdo_r <= 1'b0;
        end else begin
            unique case (phase_r)
                srp_pkg::SRP_CMD: begin
                    if (sclkRise) begin
                        rxShift_r <= rxByte[6:0];
                        bitCnt_r <= bitCnt_r + 3'h1;
                    end
                    // command byte: address above, direction in bit 0
                    if (byteDone) begin
                        ptr_r <= rxByte[`SRP_CMD_ADDR_MSB:
                            `SRP_CMD_ADDR_LSB];
                        if (rxByte[`SRP_CMD_RW_BIT]) begin
                            phase_r <= srp_pkg::SRP_READ;
                            txShift_r <= regRead(rxByte[
                                `SRP_CMD_ADDR_MSB:`SRP_CMD_ADDR_LSB]);
                        end else begin
                            phase_r <= srp_pkg::SRP_WRITE;
                        end
                    end
                end
                srp_pkg::SRP_WRITE: begin
                    if (sclkRise) begin
                        rxShift_r <= rxByte[6:0];
                        bitCnt_r <= bitCnt_r + 3'h1;
                    end
                    // pointer moves even when the byte was dropped
                    if (byteDone) begin
                        ptr_r <= nextAddr(ptr_r);
                    end
                end
                srp_pkg::SRP_READ: begin
                    // input is ignored; falling edges drive the output
                    if (sclkFall) begin
                        sdo_r <= txShift_r[7];
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == `SRP_BYTE_LAST_BIT) begin
                            ptr_r <= nextAddr(ptr_r);
                            txShift_r <= regRead(nextAddr(ptr_r));
                        end else begin
                            txShift_r <= {txShift_r[6:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    // output driven only inside an active read burst
    assign sdoOe = active && (phase_r == srp_pkg::SRP_READ);
    assign sdo = sdo_r;

    // ------------------------------------------------------------------
    // register array
    // ------------------------------------------------------------------
    assign wrHit = byteDone && (phase_r == srp_pkg::SRP_WRITE)
        && writable(ptr_r);

    // the array is written at once, so a slow consumer never costs data
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= resetValue(i);
            end
        end else if (wrHit) begin
            regs_r[ptr_r[4:0]] <= rxByte;
        end
    end

    assign cfgRegs = regs_r;

    // ------------------------------------------------------------------
    // two-entry write stream buffer
    // ------------------------------------------------------------------
    assign fifoFull = (fifoCnt_r == 2'h2);
    assign push = wrHit && !fifoFull;
    assign pop = cfgValid && cfgReady;
    assign cfgValid = (fifoCnt_r != 2'h0);
    assign cfgWord = fifoMem_r[rdIdx_r];

    // storage; a byte takes 64 clocks at most rates, so two slots ride out
    // short consumer stalls
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fifoMem_r[0] <= '0;
            fifoMem_r[1] <= '0;
        end else if (push) begin
            fifoMem_r[wrIdx_r] <= '{addr: ptr_r, data: rxByte};
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrIdx_r <= 1'b0;
            rdIdx_r <= 1'b0;
            fifoCnt_r <= 2'h0;
        end else begin
            if (push) begin
                wrIdx_r <= ~wrIdx_r;
            end
            if (pop) begin
                rdIdx_r <= ~rdIdx_r;
            end
            if (push && !pop) begin
                fifoCnt_r <= fifoCnt_r + 2'h1;
            end else if (pop && !push) begin
                fifoCnt_r <= fifoCnt_r - 2'h1;
            end
        end
    end

    // sticky flag: a notification was lost though the register took it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            overrun_r <= 1'b0;
        end else if (wrHit && fifoFull) begin
            overrun_r <= 1'b1;
        end
    end

    assign overrun = overrun_r;

endmodule : srp_serial_register_port

// *** tb/srp_serial_register_port_asserts.sv ***
// concurrent checks on the serial register port pins and write stream
`timescale 1ns/1ps
`include "srp_consts.svh"

module srp_serial_register_port_asserts #(
    parameter int REG_COUNT = `SRP_REG_COUNT
) (
    input logic clk_sys,
    input logic resetn,
    input logic csN,
    input logic sclk,
    input logic sdi,
    input logic [`SRP_STATUS_W-1:0] statusIn,
    input logic sdo,
    input logic sdoOe,
    input logic cfgValid,
    input logic cfgReady,
    input srp_pkg::srp_wr_t cfgWord,
    input logic [REG_COUNT-1:0][7:0] cfgRegs,
    input logic overrun
);
    // ------------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // cs sync is two stages deep, so three high samples must release sdo
    idle_release_a: assert property (csN [*3] |-> !sdoOe)
        else $error("data out driven while deselected");
    sel_oe_a: assert property ($rose(sdoOe) |->
        !csN && !$past(csN, 3))
        else $error("data out enabled without select");
    cmd_oe_a: assert property ($rose(sdoOe) |->
        $past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4))
        else $error("data out enabled away from a clock rise");
    fall_shift_a: assert property (
        sdoOe && !csN && $changed(sdo) |->
        !$past(sclk, 2) && !$past(sclk, 3))
        else $error("read bit changed after a clock rise");
    read_quiet_a: assert property ($rose(cfgValid) |-> !sdoOe)
        else $error("write stored during a read");

    // ------------------------------------------------------------------
    // register file and write stream
    // ------------------------------------------------------------------
    word_reg_a: assert property ($rose(cfgValid) |->
        cfgRegs[cfgWord.addr] == cfgWord.data)
        else $error("notified word differs from register");
    ro_skip_a: assert property (cfgValid |->
        cfgWord.addr != 7'h00 && cfgWord.addr < 7'h16)
        else $error("write to read-only place notified");
    held_word_a: assert property (cfgValid && !cfgReady |=>
        cfgValid && $stable(cfgWord))
        else $error("stalled word lost or changed");
    no_store_a: assert property (csN [*4] |=> $stable(cfgRegs))
        else $error("registers changed outside a burst");
    status_zero_a: assert property (cfgRegs[0] == 8'h00 &&
        cfgRegs[REG_COUNT-1] == 8'h00)
        else $error("read-only slot holds stored data");

    // main scenarios reached
    cover property ($rose(sdoOe));
    cover property ($rose(cfgValid));
    cover property ($rose(overrun));
    cover property (cfgValid && !cfgReady);
endmodule : srp_serial_register_port_asserts

bind srp_serial_register_port srp_serial_register_port_asserts #(
    .REG_COUNT(REG_COUNT)
) u_srp_chk (
    .clk_sys(clk_sys), .resetn(resetn), .csN(csN), .sclk(sclk),
    .sdi(sdi), .statusIn(statusIn), .sdo(sdo), .sdoOe(sdoOe),
    .cfgValid(cfgValid), .cfgReady(cfgReady), .cfgWord(cfgWord),
    .cfgRegs(cfgRegs), .overrun(overrun)
);

// *** tb/srp_master_model.sv ***
// behavioural serial bus master that drives three of the port's four pins and samples sdo
`timescale 1ns/1ps

module srp_master_model (
    input logic clk_sys,
    input logic sdo,
    input logic sdoOe,
    output logic csN,
    output logic sclk,
    output logic sdi
);
    logic lineLevel;

    // released line falls to the pull-down level, never the last bit
    assign lineLevel = sdoOe ? sdo : 1'b0;

    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // idle data toggles so a stale bit can never pass for a real one
    always @(posedge clk_sys) begin
        if (csN) begin
            sdi <= ~sdi;
        end
    end

    // one device only, so its select is the only one ever low
    task automatic open_burst();
        @(posedge clk_sys);
        csN <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : open_burst

    // 320 ns a bit: clock low 5 cycles, high 3, so data is stable at rise
    task automatic xfer(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            sdi <= w[i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            r[i] = lineLevel;
            repeat (3) @(posedge clk_sys);
            sclk <= 1'b0;
        end
    endtask : xfer

    // select high ends the burst; gap covers the port's cs sync
    task automatic close_burst();
        repeat (2) @(posedge clk_sys);
        csN <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask : close_burst
endmodule : srp_master_model

// *** tb/srp_serial_register_port_test.sv ***
// self-checking bench for the serial register port
`timescale 1ns/1ps
`include "srp_consts.svh"

module srp_serial_register_port_test;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic [7:0] want;
        logic kept;
    } srp_row_t;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic csN, sclk, sdi, sdo, sdoOe, cfgValid, overrun;
    logic cfgReady = 1'b1;
    logic [`SRP_STATUS_W-1:0] statusIn = 6'h2d;
    srp_pkg::srp_wr_t cfgWord;
    logic [`SRP_REG_COUNT-1:0][7:0] cfgRegs;
    int numErrors = 0;
    int nChecks = 0;
    int cycles = 0;
    srp_pkg::srp_wr_t popped[$];
    logic [7:0] rdq[$];
    logic [7:0] dflt[5] = '{`SRP_RST_01, `SRP_RST_02, `SRP_RST_03,
        `SRP_RST_04, `SRP_RST_05};
    // write then read back: stored place, status, id byte, unmapped, last
    srp_row_t rows[6] = '{{7'h05, 8'hab, 8'hab, 1'b1},
        {7'h00, 8'hff, 8'h2d, 1'b0}, {7'h16, 8'h3c, 8'h5a, 1'b0},
        {7'h17, 8'h77, 8'h00, 1'b0}, {7'h15, 8'hc3, 8'hc3, 1'b1},
        {7'h01, 8'h00, 8'h00, 1'b1}};

    srp_serial_register_port dut (.clk_sys(clk_sys), .resetn(resetn),
        .csN(csN), .sclk(sclk), .sdi(sdi), .statusIn(statusIn),
        .sdo(sdo), .sdoOe(sdoOe), .cfgValid(cfgValid),
        .cfgReady(cfgReady), .cfgWord(cfgWord), .cfgRegs(cfgRegs),
        .overrun(overrun));
    srp_master_model m (.clk_sys(clk_sys), .sdo(sdo), .sdoOe(sdoOe),
        .csN(csN), .sclk(sclk), .sdi(sdi));

    always #20 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // collect popped words; the cycle ceiling cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cfgValid === 1'b1 && cfgReady === 1'b1) begin
            popped.push_back(cfgWord);
        end
        if (cycles == 12000) begin
            numErrors++;
            $display("wrong value at %0t: run timed out", $time);
            conclude();
        end
    end

    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic burst(input logic [7:0] b[$]);
        logic [7:0] r;
        rdq.delete();
        m.open_burst();
        foreach (b[i]) begin
            m.xfer(b[i], r);
            rdq.push_back(r);
        end
        m.close_burst();
    endtask : burst

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (rows[i]) begin
            popped.delete();
            burst('{{rows[i].addr, 1'b0}, rows[i].data});
            check(15'(popped.size()), 15'(rows[i].kept));
            if (rows[i].kept) begin
                check(popped[0], {rows[i].addr, rows[i].data});
            end
            burst('{{rows[i].addr, 1'b1}, 8'h0a, 8'h00});
            check(15'(rdq[1]), 15'(rows[i].want));
            check(15'(popped.size()), 15'(rows[i].kept));
        end
        $display("table of single writes and reads done");

        // write across the id byte and wrap past the last address
        popped.delete();
        statusIn <= 6'h12;
        burst('{8'h2a, 8'h11, 8'h22, 8'h33, 8'h44});
        check(15'(popped.size()), 15'h2);
        check(popped[0], {7'h15, 8'h11});
        check(popped[1], {7'h01, 8'h44});
        burst('{8'h2b, 8'h00, 8'h00, 8'h00, 8'h00});
        check(15'(rdq[1]), 15'h11);
        check(15'(rdq[2]), 15'h5a);
        check(15'(rdq[3]), 15'h12);
        check(15'(rdq[4]), 15'h44);
        $display("wrap test done");

        // receiver stalls: two words wait, the third is dropped
        popped.delete();
        cfgReady <= 1'b0;
        burst('{8'h04, 8'h21, 8'h22, 8'h23});
        check(15'(overrun), 15'h1);
        check(15'(cfgRegs[4]), 15'h23);
        cfgReady <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(15'(popped.size()), 15'h2);
        check(popped[0], {7'h02, 8'h21});
        check(popped[1], {7'h03, 8'h22});
        check(15'(cfgValid), 15'h0);
        $display("stall test done");

        // second reset restores defaults and clears the sticky flag
        resetn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            check(15'(cfgRegs[i + 1]), 15'(dflt[i]));
        end
        check(15'(cfgRegs[21]), 15'(`SRP_RST_15));
        check(15'({overrun, cfgValid, sdoOe}), 15'h0);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        burst('{8'h0b, 8'h00});
        check(15'(rdq[1]), 15'(`SRP_RST_05));
        $display("reset test done");
        conclude();
    end
endmodule : srp_serial_register_port_test
